// ==== design/hisf_flags.sv ====
// Interrupt status flags, clear-on-read, plus single-ended output routing.
// Assumes event inputs and the read port come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module hisf_flags #(
  parameter int SAMPLE_W = 16
) (
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire hisf_pkg::hisf_events_t I_EVENTS,
  input wire logic I_POWER_LIMIT_IRQ_ENABLE,
  input wire logic [1:0] I_PLAYBACK_SOURCE_SELECT,
  input wire hisf_pkg::hisf_rd_req_t I_RD,
  input wire logic I_SINGLE_ENDED,
  input wire logic signed [SAMPLE_W-1:0] I_SAMPLE,
  output logic [15:0] O_RD_DATA,
  output logic O_RD_VALID,
  output logic [SAMPLE_W-1:0] O_OUT_POS,
  output logic [SAMPLE_W-1:0] O_OUT_NEG
);

  localparam int NF = hisf_pkg::NUM_FLAGS;
  localparam int RD_W = 16;
  localparam int PAD_W = RD_W - NF;

  // Flag state and its update terms
  logic [NF-1:0] set_vec;
  logic [NF-1:0] clr_vec;
  logic [NF-1:0] flags_r;
  logic [NF-1:0] flags_nxt;
  logic status_read;
  logic [RD_W-1:0] rd_data_nxt;
  logic rd_valid_nxt;
  logic sample_is_neg;
  logic [SAMPLE_W-1:0] sample_mag_neg;
  logic [SAMPLE_W-1:0] out_pos_nxt;
  logic [SAMPLE_W-1:0] out_neg_nxt;

  // Address decode shared by the clear path and the read data path
  function automatic logic hits_status(input hisf_pkg::hisf_rd_req_t req);
    hits_status = req.rd && (req.addr == hisf_pkg::INT_FLAGS_ADDR);
  endfunction

  // Flag position to event field; positions follow the status layout
  function automatic logic event_at(
    input int idx,
    input hisf_pkg::hisf_events_t ev
  );
    event_at = 1'b0;
    unique case (idx)
      hisf_pkg::BIT_FAULT: begin
        event_at = ev.fault;
      end
      hisf_pkg::BIT_POWER_LIMIT: begin
        event_at = ev.power_at_max;
      end
      hisf_pkg::BIT_PLAYBACK: begin
        event_at = ev.playback;
      end
      hisf_pkg::BIT_SENSE_DETECT: begin
        event_at = ev.sense_detect;
      end
      hisf_pkg::BIT_OUTPUT_DEVIATION: begin
        event_at = ev.output_deviation;
      end
      hisf_pkg::BIT_STATE_CHANGE: begin
        event_at = ev.state_change;
      end
      hisf_pkg::BIT_FIFO_HALF_EMPTY: begin
        event_at = ev.fifo_half_empty;
      end
      default: begin
        event_at = 1'b0;
      end
    endcase
  endfunction

  // Only two flags carry an extra gate from configuration
  function automatic logic flag_gate(
    input int idx,
    input logic pwr_en,
    input logic [1:0] src
  );
    flag_gate = 1'b1;
    unique case (idx)
      hisf_pkg::BIT_POWER_LIMIT: begin
        flag_gate = (pwr_en == hisf_pkg::POWER_IRQ_ON);
      end
      hisf_pkg::BIT_FIFO_HALF_EMPTY: begin
        flag_gate = (src == hisf_pkg::PLAY_SRC_FIFO);
      end
      default: begin
        flag_gate = 1'b1;
      end
    endcase
  endfunction

  // Wraps at the most negative code, which the host must not program
  function automatic logic [SAMPLE_W-1:0] negate(input logic signed [SAMPLE_W-1:0] s);
    negate = SAMPLE_W'(-s);
  endfunction

  always_comb begin
    status_read = hits_status(I_RD);
  end

  // Valid pulses for every read, decoded or not
  always_comb begin
    rd_valid_nxt = I_RD.rd;
  end

  // Clear hits all flags at once
  always_comb begin
    clr_vec = '0;
    if (status_read) begin
      clr_vec = '1;
    end
  end

  // Set beats the read clear so an event in the read cycle is not lost
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : gen_flag
      always_comb begin
        set_vec[g] = event_at(g, I_EVENTS) && flag_gate(g, I_POWER_LIMIT_IRQ_ENABLE, I_PLAYBACK_SOURCE_SELECT);
      end

      always_comb begin
        flags_nxt[g] = (flags_r[g] && !clr_vec[g]) || set_vec[g];
      end

      always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
          flags_r[g] <= hisf_pkg::INT_FLAGS_RESET[g];
        end else begin
          flags_r[g] <= flags_nxt[g];
        end
      end
    end
  endgenerate

  // Read returns the pre-clear snapshot; reserved bits read zero
  genvar b;
  generate
    for (b = 0; b < RD_W; b++) begin : gen_rd_bit
      if (b < NF) begin : gen_live
        always_comb begin
          rd_data_nxt[b] = status_read && flags_r[b];
        end
      end else begin : gen_rsvd
        always_comb begin
          rd_data_nxt[b] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= rd_valid_nxt;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RD_DATA <= '0;
    end else begin
      O_RD_DATA <= rd_data_nxt;
    end
  end

  // Sign and magnitude of the programmed sample
  always_comb begin
    sample_is_neg = I_SAMPLE[SAMPLE_W-1];
    sample_mag_neg = negate(I_SAMPLE);
  end

  // Single-ended split relies on the host programming a bipolar waveform
  always_comb begin
    out_pos_nxt = I_SAMPLE;
    out_neg_nxt = sample_mag_neg;
    if (I_SINGLE_ENDED) begin
      out_pos_nxt = sample_is_neg ? '0 : I_SAMPLE;
      out_neg_nxt = sample_is_neg ? sample_mag_neg : '0;
    end
  end

  // Positive output drives the first load
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_OUT_POS <= '0;
    end else begin
      O_OUT_POS <= out_pos_nxt;
    end
  end

  // Negative output carries the negated sample, or in single-ended mode the magnitude of a negative one, for the second load
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_OUT_NEG <= '0;
    end else begin
      O_OUT_NEG <= out_neg_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== design/hisf_pkg.sv ====
// Constants and carrier types for the haptic interrupt status flag block.
// Assumes a single 10 MHz device clock and an active-low asynchronous reset.
package hisf_pkg;

  localparam logic [7:0] INT_FLAGS_ADDR = 8'h1F;
  localparam logic [15:0] INT_FLAGS_RESET = 16'h0000;

  localparam int BIT_FAULT = 0;
  localparam int BIT_POWER_LIMIT = 1;
  localparam int BIT_PLAYBACK = 2;
  localparam int BIT_SENSE_DETECT = 3;
  localparam int BIT_OUTPUT_DEVIATION = 4;
  localparam int BIT_STATE_CHANGE = 5;
  localparam int BIT_FIFO_HALF_EMPTY = 6;
  localparam int NUM_FLAGS = 7;

  localparam logic [1:0] PLAY_SRC_FIFO = 2'h1;
  localparam logic POWER_IRQ_ON = 1'h1;

  // Raw event inputs from the driver core, one cycle or level
  typedef struct packed {
    logic fifo_half_empty;
    logic state_change;
    logic output_deviation;
    logic sense_detect;
    logic playback;
    logic power_at_max;
    logic fault;
  } hisf_events_t;

  // Register read port
  typedef struct packed {
    logic rd;
    logic [7:0] addr;
  } hisf_rd_req_t;

endpackage

// ==== verification/hisf_chk_assertions.sv ====
// Port checks for hisf_flags
// Bound to every instance
`timescale 1ns/1ns
`default_nettype none
module hisf_chk #(parameter int SAMPLE_W = 16) (
  input wire logic I_CLOCK, I_ARST_N, I_POWER_LIMIT_IRQ_ENABLE, I_SINGLE_ENDED, O_RD_VALID,
  input wire hisf_pkg::hisf_events_t I_EVENTS,
  input wire hisf_pkg::hisf_rd_req_t I_RD,
  input wire logic [1:0] I_PLAYBACK_SOURCE_SELECT,
  input wire logic signed [SAMPLE_W-1:0] I_SAMPLE,
  input wire logic [15:0] O_RD_DATA,
  input wire logic [SAMPLE_W-1:0] O_OUT_POS, O_OUT_NEG);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  wire logic rs = I_RD.rd && I_RD.addr == 8'h1F;
  wire logic pw = I_EVENTS[1] && I_POWER_LIMIT_IRQ_ENABLE;
  a_dev_set: assert property (I_EVENTS[4] ##1 rs |=> O_RD_DATA[4]) else $error("dev");
  a_dev_clear: assert property (rs && !I_EVENTS[4] ##1 rs |=> !O_RD_DATA[4]) else $error("dev");
  a_pwr_set: assert property (pw ##1 rs |=> O_RD_DATA[1]) else $error("pwr");
  a_pwr_clear: assert property (rs && !pw ##1 rs |=> !O_RD_DATA[1]) else $error("pwr");
  a_half_set: assert property (I_EVENTS[6] && I_PLAYBACK_SOURCE_SELECT == 2'h1 ##1 rs |=> O_RD_DATA[6]) else $error("fhe");
  a_rd_answer: assert property (I_RD.rd |=> O_RD_VALID && O_RD_DATA[15:7] == 9'h000) else $error("rd");
  a_rd_other: assert property (I_RD.rd && !rs |=> O_RD_DATA == 16'h0000) else $error("adr");
  a_route_se: assert property (I_SINGLE_ENDED |=> O_OUT_POS - O_OUT_NEG == $past(I_SAMPLE) &&
    (O_OUT_NEG != '0) == $past(I_SAMPLE[SAMPLE_W-1])) else $error("se");
endmodule
bind hisf_flags hisf_chk #(.SAMPLE_W(SAMPLE_W)) u_chk(.*);
`default_nettype wire

// ==== verification/hisf_host.sv ====
// Host model issuing status reads
// Answer expected one cycle after the strobe
`timescale 1ns/1ns
`default_nettype none
module hisf_host (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [15:0] i_data,
  output var hisf_pkg::hisf_rd_req_t o_req
);
  initial o_req = '0;
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge i_clk) o_req <= '{1'b1, a};
    @(posedge i_clk) o_req <= '0;
    @(posedge i_clk) q = i_valid ? i_data : 16'hDEAD;
  endtask
endmodule
`default_nettype wire

// ==== verification/hisf_flags_tb.sv ====
// Bench for hisf_flags
// Host model does all reads
`timescale 1ns/1ns
`default_nettype none
module hisf_flags_tb;
  logic clk = 0, rst_n = 0, en = 1, se = 0, v;
  logic [1:0] src = 2'h1;
  logic signed [15:0] smp = '0;
  logic [15:0] d, q, p, n;
  hisf_pkg::hisf_events_t ev = '0;
  hisf_pkg::hisf_rd_req_t rq;
  int bad_count = 0, cmp_count = 0;
  hisf_flags u_hisf_flags(.I_CLOCK(clk), .I_ARST_N(rst_n), .I_EVENTS(ev), .I_POWER_LIMIT_IRQ_ENABLE(en),
    .I_PLAYBACK_SOURCE_SELECT(src), .I_RD(rq), .I_SINGLE_ENDED(se), .I_SAMPLE(smp), .O_RD_DATA(d),
    .O_RD_VALID(v), .O_OUT_POS(p), .O_OUT_NEG(n));
  hisf_host u_hisf_host(.i_clk(clk), .i_valid(v), .i_data(d), .o_req(rq));
  task automatic chk(input string nm, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic flags;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk) ev <= 7'(1 << i);
      @(posedge clk) ev <= '0;
      u_hisf_host.rd(8'h1F, q); chk("set", q, 16'(1 << i));
      u_hisf_host.rd(8'h1F, q); chk("clr", q, 16'h0000);
    end
  endtask
  task automatic gate;
    @(posedge clk) begin en <= 0; src <= 2'h0; ev <= 7'h42; end
    @(posedge clk) ev <= '0;
    u_hisf_host.rd(8'h1E, q); chk("other", q, 16'h0000);
    u_hisf_host.rd(8'h1F, q); chk("gate", q, 16'h0000);
  endtask
  task automatic setwin;
    @(posedge clk) ev <= 7'h10;
    u_hisf_host.rd(8'h1F, q); chk("win", q, 16'h0010);
    ev <= '0;
    u_hisf_host.rd(8'h1F, q); chk("kept", q, 16'h0010);
    u_hisf_host.rd(8'h1F, q); chk("gone", q, 16'h0000);
  endtask
  task automatic route;
    logic [15:0] t [2] = '{16'h0007, 16'hFFF9}; // Bipolar, both loads
    se <= 1;
    foreach (t[i]) begin
      @(posedge clk) smp <= t[i];
      @(posedge clk);
      @(negedge clk) chk("pos", p, t[i][15] ? '0 : t[i]);
      chk("neg", n, t[i][15] ? -t[i] : '0);
    end
    @(posedge clk) se <= 0;
    @(posedge clk);
    @(negedge clk) chk("dpos", p, t[1]);
    chk("dneg", n, -t[1]);
  endtask
  task automatic give_verdict;
    $display("mismatches %0d of %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #50 clk = ~clk;
  initial begin #1000000 bad_count++; give_verdict; end // Hang cutoff
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    u_hisf_host.rd(8'h1F, q); chk("rst", q, 16'h0000);
    flags; gate; setwin; route;
    give_verdict;
  end
endmodule
`default_nettype wire
